// [logic/t16_pkg.sv]
// Register map, field positions and mode codes of the 16-bit timer
`default_nettype none
package t16_pkg;
	// Register byte offsets
	localparam logic [7:0] ADDR_FLAGS   = 8'h0B;
	localparam logic [7:0] ADDR_MASK    = 8'h0C;
	localparam logic [7:0] ADDR_FORCE   = 8'h22;
	localparam logic [7:0] ADDR_CAP_L   = 8'h24;
	localparam logic [7:0] ADDR_CAP_H   = 8'h25;
	localparam logic [7:0] ADDR_CMPA_L  = 8'h26;
	localparam logic [7:0] ADDR_CMPA_H  = 8'h27;
	localparam logic [7:0] ADDR_CMPB_L  = 8'h28;
	localparam logic [7:0] ADDR_CMPB_H  = 8'h29;
	localparam logic [7:0] ADDR_CNT_L   = 8'h2C;
	localparam logic [7:0] ADDR_CNT_H   = 8'h2D;
	localparam logic [7:0] ADDR_CTRL_B  = 8'h2E;
	localparam logic [7:0] ADDR_CTRL_A  = 8'h2F;
	// Field positions
	localparam int BIT_CAP     = 5;
	localparam int BIT_MB      = 2;
	localparam int BIT_MA      = 1;
	localparam int BIT_OVF     = 0;
	localparam int BIT_FORCE_A = 7;
	localparam int BIT_FORCE_B = 6;
	localparam int BIT_NOISE   = 7;
	localparam int BIT_EDGE    = 6;
	// Writable bits of mask/flags and of control B
	localparam logic [7:0] IRQ_BITS    = 8'h27;
	localparam logic [7:0] CTRL_B_BITS = 8'hDF;
	localparam logic [7:0] RESET_BYTE  = 8'h00;
	localparam logic [15:0] CNT_MAX    = 16'hFFFF;
	// Clock select codes
	localparam logic [2:0] CS_STOP  = 3'h0;
	localparam logic [2:0] CS_DIV1  = 3'h1;
	localparam logic [2:0] CS_DIV8  = 3'h2;
	localparam logic [2:0] CS_DIV64 = 3'h3;
	localparam logic [2:0] CS_DIV256  = 3'h4;
	localparam logic [2:0] CS_DIV1024 = 3'h5;
	localparam logic [2:0] CS_EXT_FALL = 3'h6;
	localparam logic [2:0] CS_EXT_RISE = 3'h7;
	localparam int PRESC_W = 10;
	// Waveform modes
	localparam logic [3:0] WM_NORMAL  = 4'h0;
	localparam logic [3:0] WM_CTC_A   = 4'h4;
	localparam logic [3:0] WM_CTC_CAP = 4'hC;
	localparam logic [3:0] WM_RSVD    = 4'hD;
	// Compare output modes
	localparam logic [1:0] COM_OFF    = 2'h0;
	localparam logic [1:0] COM_TOGGLE = 2'h1;
	localparam logic [1:0] COM_CLEAR  = 2'h2;
	localparam logic [1:0] COM_SET    = 2'h3;
	// Noise filter length in samples
	localparam int FILT_LEN = 4;
	typedef enum logic {
		T16_DIR_UP   = 1'b0,
		T16_DIR_DOWN = 1'b1
	} t16_dir_e;
endpackage
`default_nettype wire

// [logic/t16_timer.sv]
// 16-bit timer with capture, two compare channels and shared high-byte latch
// What this block does
// - Edge select bit picks falling or rising capture
// - Capture copies counter and sets capture flag
// - Capture input ignored when capture sets top
// - Then capture flag sets when counter hits top
// - Clock select: stop, prescaled taps, external edges
// - External pin counts regardless of pin direction
// - Force bit makes immediate match in non-PWM
// - Forced match sets no flag, no clear
// - Force bits always read as zero
// - 16-bit access through one shared high latch
// - Counter write blocks next timer-clock match
// - Compare registers continuously matched with counter
// - Capture source pin or comparator; may be top
// - Mask bits gate flags with global enable
// - Reserved mask and flag bits read zero
// - Match flag set on tick after equality
// - Flags clear by vector ack or write one
// - Noise filter needs four equal samples
// - Overflow flag set per waveform mode
`default_nettype none
module t16_timer (
	input  wire logic       clk,
	input  wire logic       rstn,
	input  wire logic [7:0] addr,
	input  wire logic [7:0] wdata,
	input  wire logic       wr_en,
	input  wire logic       rd_en,
	output logic      [7:0] rdata,
	input  wire logic       capture_in_pin,
	input  wire logic       comparator_in,
	input  wire logic       capture_src_comp,
	input  wire logic       ext_count_pin,
	input  wire logic       global_irq_en,
	input  wire logic       ack_capture,
	input  wire logic       ack_match_a,
	input  wire logic       ack_match_b,
	input  wire logic       ack_overflow,
	output logic            irq_capture,
	output logic            irq_match_a,
	output logic            irq_match_b,
	output logic            irq_overflow,
	output logic            wave_out_a,
	output logic            wave_out_b
);
	logic [7:0]  ctrl_a_q;
	logic [7:0]  ctrl_b_q;
	logic [7:0]  mask_q;
	logic [7:0]  flags_q;
	logic [7:0]  temp_q;
	logic [15:0] cnt_q;
	logic [15:0] cmp_q [2];
	logic [15:0] cap_q;
	localparam int PRESC_W_L = t16_pkg::PRESC_W;
	logic [7:0]  rdata_q;
	logic [PRESC_W_L-1:0] presc_q;
	t16_pkg::t16_dir_e dir_q;
	logic        block_q;
	logic [1:0]  wave_q;
	logic [3:0]  irq_q;

	// Decoded mode
	logic [3:0]  wm;
	logic [2:0]  cs;
	logic        pwm_phase;
	logic        pwm_fast;
	logic        cap_is_top;
	logic [15:0] top;
	assign wm = {ctrl_b_q[4:3], ctrl_a_q[1:0]};
	assign cs = ctrl_b_q[2:0];

	// Top value per waveform code; reserved code behaves as normal
	always_comb begin
		cap_is_top = 1'b0;
		top        = t16_pkg::CNT_MAX;
		case (wm)
			4'h1, 4'h5: top = 16'h00FF;
			4'h2, 4'h6: top = 16'h01FF;
			4'h3, 4'h7: top = 16'h03FF;
			4'h4, 4'h9, 4'hB, 4'hF: top = cmp_q[0];
			4'h8, 4'hA, 4'hC, 4'hE: begin
				cap_is_top = 1'b1;
				top        = cap_q;
			end
			default: top = t16_pkg::CNT_MAX;
		endcase
	end
	assign pwm_phase = (wm inside {4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'hA, 4'hB});
	assign pwm_fast  = (wm inside {4'h5, 4'h6, 4'h7, 4'hE, 4'hF});

	// Bus decode
	logic wr_lo_cnt;
	logic wr_force;
	assign wr_lo_cnt = wr_en && (addr == t16_pkg::ADDR_CNT_L);
	assign wr_force  = wr_en && (addr == t16_pkg::ADDR_FORCE);

	// Input synchronisers; first stages feed only the second stages
	logic [2:0] sync1_q;
	logic [2:0] sync2_q;
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			sync1_q <= 3'h0;
			sync2_q <= 3'h0;
		end else begin
			sync1_q <= {ext_count_pin, comparator_in, capture_in_pin};
			sync2_q <= sync1_q;
		end
	end

	// Free-running prescaler shared by all taps
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			presc_q <= '0;
		end else begin
			presc_q <= presc_q + 1'b1;
		end
	end

	// External pin edge detect; pin direction plays no part
	logic ext_prev_q;
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ext_prev_q <= 1'b0;
		end else begin
			ext_prev_q <= sync2_q[2];
		end
	end

	// Timer clock tick select
	logic tick;
	always_comb begin
		case (cs)
			t16_pkg::CS_STOP:     tick = 1'b0;
			t16_pkg::CS_DIV1:     tick = 1'b1;
			t16_pkg::CS_DIV8:     tick = &presc_q[2:0];
			t16_pkg::CS_DIV64:    tick = &presc_q[5:0];
			t16_pkg::CS_DIV256:   tick = &presc_q[7:0];
			t16_pkg::CS_DIV1024:  tick = &presc_q[9:0];
			t16_pkg::CS_EXT_FALL: tick = ext_prev_q && !sync2_q[2];
			t16_pkg::CS_EXT_RISE: tick = !ext_prev_q && sync2_q[2];
			default:              tick = 1'b0;
		endcase
	end

	// Capture source and noise filter
	localparam int FILT_N = t16_pkg::FILT_LEN;
	logic                cap_raw;
	logic [FILT_N-1:0]   filt_hist_q;
	logic                filt_q;
	logic                cap_prev_q;
	logic                cap_lvl;
	assign cap_raw = capture_src_comp ? sync2_q[1] : sync2_q[0];
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			filt_hist_q <= '0;
			filt_q      <= 1'b0;
		end else begin
			filt_hist_q <= {filt_hist_q[FILT_N-2:0], cap_raw};
			if (&filt_hist_q || ~|filt_hist_q) begin
				filt_q <= filt_hist_q[FILT_N-1];
			end
		end
	end
	assign cap_lvl = ctrl_b_q[t16_pkg::BIT_NOISE] ? filt_q : cap_raw;
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cap_prev_q <= 1'b0;
		end else begin
			cap_prev_q <= cap_lvl;
		end
	end

	// Capture event; input disconnected when capture value is top
	logic cap_evt;
	assign cap_evt = !cap_is_top &&
		(ctrl_b_q[t16_pkg::BIT_EDGE] ? (cap_lvl && !cap_prev_q)
		                              : (!cap_lvl && cap_prev_q));

	// Per-channel match detect and waveform unit
	logic [1:0] match;
	logic [1:0] force_hit;
	logic [1:0] ch_force_bit;
	assign ch_force_bit = {wdata[t16_pkg::BIT_FORCE_B], wdata[t16_pkg::BIT_FORCE_A]};
	genvar ch;
	generate
		for (ch = 0; ch < 2; ch++) begin : g_ch
			logic [1:0] com;
			logic       wave_ch_q;
			assign com           = ch ? ctrl_a_q[5:4] : ctrl_a_q[7:6];
			assign match[ch]     = tick && !block_q && (cnt_q == cmp_q[ch]);
			assign force_hit[ch] = wr_force && ch_force_bit[ch] && !pwm_fast && !pwm_phase;
			assign wave_q[ch]    = wave_ch_q;
			// Wave output follows compare output mode; forced hits act here only
			always_ff @(posedge clk or negedge rstn) begin
				if (!rstn) begin
					wave_ch_q <= 1'b0;
				end else if (!pwm_fast && !pwm_phase) begin
					if (match[ch] || force_hit[ch]) begin
						case (com)
							t16_pkg::COM_TOGGLE: wave_ch_q <= !wave_ch_q;
							t16_pkg::COM_CLEAR:  wave_ch_q <= 1'b0;
							t16_pkg::COM_SET:    wave_ch_q <= 1'b1;
							default:             wave_ch_q <= wave_ch_q;
						endcase
					end
				end else if (com[1]) begin
					if (match[ch]) begin
						wave_ch_q <= pwm_fast ? com[0] : (com[0] ^ (dir_q == t16_pkg::T16_DIR_DOWN));
					end else if (pwm_fast && tick && cnt_q == top) begin
						wave_ch_q <= !com[0];
					end
				end
			end
		end
	endgenerate
	assign wave_out_a = wave_q[0];
	assign wave_out_b = wave_q[1];

	// Counter, direction and match block
	logic at_top;
	assign at_top = (cnt_q == top);
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cnt_q   <= 16'h0000;
			dir_q   <= t16_pkg::T16_DIR_UP;
			block_q <= 1'b0;
		end else if (wr_lo_cnt) begin
			cnt_q   <= {temp_q, wdata};
			block_q <= 1'b1;
		end else if (tick) begin
			block_q <= 1'b0;
			if (pwm_phase) begin
				if (dir_q == t16_pkg::T16_DIR_UP) begin
					if (at_top) begin
						dir_q <= t16_pkg::T16_DIR_DOWN;
						cnt_q <= cnt_q - 1'b1;
					end else begin
						cnt_q <= cnt_q + 1'b1;
					end
				end else if (cnt_q == 16'h0000) begin
					dir_q <= t16_pkg::T16_DIR_UP;
					cnt_q <= cnt_q + 1'b1;
				end else begin
					cnt_q <= cnt_q - 1'b1;
				end
			end else if ((pwm_fast || wm == t16_pkg::WM_CTC_A || wm == t16_pkg::WM_CTC_CAP)
			             && at_top) begin
				cnt_q <= 16'h0000;
			end else begin
				cnt_q <= cnt_q + 1'b1;
			end
		end
	end

	// Flag set events
	logic [7:0] set_ev;
	logic [7:0] clr_ev;
	logic       ovf_ev;
	always_comb begin
		if (pwm_phase) begin
			ovf_ev = tick && cnt_q == 16'h0000 && dir_q == t16_pkg::T16_DIR_DOWN;
		end else if (pwm_fast) begin
			ovf_ev = tick && at_top;
		end else begin
			ovf_ev = tick && cnt_q == t16_pkg::CNT_MAX;
		end
	end
	always_comb begin
		set_ev = 8'h00;
		set_ev[t16_pkg::BIT_CAP] = cap_evt || (cap_is_top && tick && at_top);
		set_ev[t16_pkg::BIT_MA]  = match[0];
		set_ev[t16_pkg::BIT_MB]  = match[1];
		set_ev[t16_pkg::BIT_OVF] = ovf_ev;
		clr_ev = (wr_en && addr == t16_pkg::ADDR_FLAGS) ? wdata : 8'h00;
		clr_ev[t16_pkg::BIT_CAP] = clr_ev[t16_pkg::BIT_CAP] || ack_capture;
		clr_ev[t16_pkg::BIT_MA]  = clr_ev[t16_pkg::BIT_MA] || ack_match_a;
		clr_ev[t16_pkg::BIT_MB]  = clr_ev[t16_pkg::BIT_MB] || ack_match_b;
		clr_ev[t16_pkg::BIT_OVF] = clr_ev[t16_pkg::BIT_OVF] || ack_overflow;
	end

	// Sticky flags; a set in the clearing cycle wins
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			flags_q <= t16_pkg::RESET_BYTE;
		end else begin
			flags_q <= ((flags_q & ~clr_ev) | set_ev) & t16_pkg::IRQ_BITS;
		end
	end

	// Interrupt requests gated by mask and global enable
	logic [7:0] pend;
	assign pend = flags_q & mask_q & {8{global_irq_en}};
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			irq_q <= 4'h0;
		end else begin
			irq_q <= {pend[t16_pkg::BIT_CAP], pend[t16_pkg::BIT_MB],
			          pend[t16_pkg::BIT_MA], pend[t16_pkg::BIT_OVF]};
		end
	end
	assign irq_capture  = irq_q[3];
	assign irq_match_b  = irq_q[2];
	assign irq_match_a  = irq_q[1];
	assign irq_overflow = irq_q[0];

	// Control, mask and compare registers
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ctrl_a_q <= t16_pkg::RESET_BYTE;
			ctrl_b_q <= t16_pkg::RESET_BYTE;
			mask_q   <= t16_pkg::RESET_BYTE;
			cmp_q[0] <= 16'h0000;
			cmp_q[1] <= 16'h0000;
		end else if (wr_en) begin
			case (addr)
				t16_pkg::ADDR_CTRL_A: ctrl_a_q <= wdata;
				t16_pkg::ADDR_CTRL_B: ctrl_b_q <= wdata & t16_pkg::CTRL_B_BITS;
				t16_pkg::ADDR_MASK:   mask_q   <= wdata & t16_pkg::IRQ_BITS;
				t16_pkg::ADDR_CMPA_L: cmp_q[0] <= {temp_q, wdata};
				t16_pkg::ADDR_CMPB_L: cmp_q[1] <= {temp_q, wdata};
				default:              ctrl_a_q <= ctrl_a_q;
			endcase
		end
	end

	// Capture register: loaded by events, writable by software
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cap_q <= 16'h0000;
		end else if (wr_en && addr == t16_pkg::ADDR_CAP_L) begin
			cap_q <= {temp_q, wdata};
		end else if (cap_evt) begin
			cap_q <= cnt_q;
		end
	end

	// Shared high-byte latch: loaded by high writes and low reads
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			temp_q <= 8'h00;
		end else if (wr_en && (addr == t16_pkg::ADDR_CNT_H || addr == t16_pkg::ADDR_CMPA_H ||
		                       addr == t16_pkg::ADDR_CMPB_H || addr == t16_pkg::ADDR_CAP_H)) begin
			temp_q <= wdata;
		end else if (rd_en) begin
			case (addr)
				t16_pkg::ADDR_CNT_L:  temp_q <= cnt_q[15:8];
				t16_pkg::ADDR_CMPA_L: temp_q <= cmp_q[0][15:8];
				t16_pkg::ADDR_CMPB_L: temp_q <= cmp_q[1][15:8];
				t16_pkg::ADDR_CAP_L:  temp_q <= cap_q[15:8];
				default:              temp_q <= temp_q;
			endcase
		end
	end

	// Read data, valid only in the cycle after the strobe
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rdata_q <= 8'h00;
		end else if (rd_en) begin
			case (addr)
				t16_pkg::ADDR_FLAGS:  rdata_q <= flags_q;
				t16_pkg::ADDR_MASK:   rdata_q <= mask_q;
				t16_pkg::ADDR_FORCE:  rdata_q <= 8'h00;
				t16_pkg::ADDR_CTRL_A: rdata_q <= ctrl_a_q;
				t16_pkg::ADDR_CTRL_B: rdata_q <= ctrl_b_q;
				t16_pkg::ADDR_CNT_L:  rdata_q <= cnt_q[7:0];
				t16_pkg::ADDR_CMPA_L: rdata_q <= cmp_q[0][7:0];
				t16_pkg::ADDR_CMPB_L: rdata_q <= cmp_q[1][7:0];
				t16_pkg::ADDR_CAP_L:  rdata_q <= cap_q[7:0];
				t16_pkg::ADDR_CNT_H, t16_pkg::ADDR_CMPA_H,
				t16_pkg::ADDR_CMPB_H, t16_pkg::ADDR_CAP_H: rdata_q <= temp_q;
				default:              rdata_q <= 8'h00;
			endcase
		end else begin
			rdata_q <= 8'h00;
		end
	end
	assign rdata = rdata_q;
endmodule
`default_nettype wire

// [testbench/t16_timer_properties.sv]
// Bus and interrupt properties of the 16-bit timer, bound to its top
`default_nettype none
module t16_timer_properties (
	input wire logic       clk,
	input wire logic       rstn,
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic       wr_en,
	input wire logic       rd_en,
	input wire logic [7:0] rdata,
	input wire logic       global_irq_en,
	input wire logic       ack_match_a,
	input wire logic       irq_capture,
	input wire logic       irq_match_a,
	input wire logic       irq_match_b,
	input wire logic       irq_overflow
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	// Any request line up
	wire logic any_irq = irq_capture | irq_match_a | irq_match_b | irq_overflow;
	// Reads of force, mask and flags; write-then-read of the mask
	chk_force_zero: assert property (
		rd_en && addr == t16_pkg::ADDR_FORCE |=> rdata == 8'h00)
		else $error("force register read not zero");
	chk_mask_rsvd: assert property (
		rd_en && addr == t16_pkg::ADDR_MASK |=> !(|rdata[7:6]) && !(|rdata[4:3]))
		else $error("mask reserved bits set");
	chk_flag_rsvd: assert property (
		rd_en && addr == t16_pkg::ADDR_FLAGS |=> (rdata & 8'hD8) == 8'h00)
		else $error("flag reserved bits set");
	chk_mask_bits: assert property (
		wr_en && addr == t16_pkg::ADDR_MASK ##2 rd_en && addr == t16_pkg::ADDR_MASK
		|=> rdata == ($past(wdata, 3) & t16_pkg::IRQ_BITS))
		else $error("mask read differs from written enables");
	// Interrupt gating and clearing; the line lags the flag by one cycle
	chk_irq_gate: assert property (!$past(global_irq_en) |-> !any_irq)
		else $error("interrupt while globally disabled");
	chk_irq_mask: assert property (
		wr_en && addr == t16_pkg::ADDR_MASK && wdata == 8'h00 |=> ##1 !any_irq)
		else $error("interrupt after mask cleared");
	chk_ack_clear: assert property (ack_match_a |=> ##1 !irq_match_a)
		else $error("match A request after vector ack");
	chk_wone_clear: assert property (
		wr_en && addr == t16_pkg::ADDR_FLAGS && wdata[t16_pkg::BIT_MB] |=> ##1 !irq_match_b)
		else $error("match B request after write one");
	cover property (irq_match_b);
	cover property (irq_capture);
	cover property (ack_match_a ##2 !irq_match_a);
endmodule
bind t16_timer t16_timer_properties u_chk (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata),
	.wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .global_irq_en(global_irq_en),
	.ack_match_a(ack_match_a), .irq_capture(irq_capture), .irq_match_a(irq_match_a),
	.irq_match_b(irq_match_b), .irq_overflow(irq_overflow));
`default_nettype wire

// [testbench/testbench.sv]
// Self-checking bench for the 16-bit timer register block
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic       clk = 1'b0;
	logic       rstn = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [7:0] wdata = 8'h00;
	logic       wr_en = 1'b0;
	logic       rd_en = 1'b0;
	logic       cap_pin = 1'b0;
	logic       ext_pin = 1'b0;
	logic       gie = 1'b0;
	logic       cmp_pin = 1'b0;
	logic       cap_src = 1'b0;
	logic [3:0] ack = 4'h0;
	logic       rd_p = 1'b0;
	logic [7:0] lo_q[$];
	logic [7:0] hi_q[$];
	logic [7:0] lo;
	logic [7:0] hi;
	wire logic [7:0] rdata;
	wire logic [3:0] irq;
	wire logic       wave_a;
	wire logic       wave_b;
	int         n_fail = 0;
	int         checked = 0;
	// Comparator path driven by the capture scenarios
	t16_timer dut (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr_en(wr_en),
		.rd_en(rd_en), .rdata(rdata), .capture_in_pin(cap_pin), .comparator_in(cmp_pin),
		.capture_src_comp(cap_src), .ext_count_pin(ext_pin), .global_irq_en(gie),
		.ack_capture(ack[0]), .ack_match_a(ack[1]), .ack_match_b(ack[2]),
		.ack_overflow(ack[3]), .irq_capture(irq[0]), .irq_match_a(irq[1]),
		.irq_match_b(irq[2]), .irq_overflow(irq[3]), .wave_out_a(wave_a), .wave_out_b(wave_b));
	always #4 clk = ~clk;
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// Read data stands only in the cycle after the strobe; a range allows tick jitter
	always @(posedge clk) rd_p <= rd_en;
	always @(negedge clk) begin
		if (rd_p) begin
			lo = lo_q.pop_front();
			hi = hi_q.pop_front();
			check(((rdata >= lo) && (rdata <= hi)) ? lo : rdata, lo);
		end
	end
	// Bus cycles keep one idle cycle between strobes
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr_en <= 1'b1;
		@(posedge clk);
		wr_en <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] l, input logic [7:0] h);
		@(posedge clk);
		addr <= a;
		rd_en <= 1'b1;
		lo_q.push_back(l);
		hi_q.push_back(h);
		@(posedge clk);
		rd_en <= 1'b0;
	endtask
	// High byte first on writes, low byte first on reads
	task automatic wr16(input logic [7:0] a, input logic [15:0] v);
		wr(a + 8'h01, v[15:8]);
		wr(a, v[7:0]);
	endtask
	task automatic rd16(input logic [7:0] a, input logic [15:0] v);
		rd(a, v[7:0], v[7:0]);
		rd(a + 8'h01, v[15:8], v[15:8]);
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic wait_irq(input int k);
		int i;
		for (i = 0; i < 3000 && irq[k] !== 1'b1; i++) @(posedge clk);
		check({7'h00, irq[k]}, 8'h01);
		if (irq[k] !== 1'b1)
			close_out();
	endtask
	initial begin
		logic [15:0] r;
		int divs[6] = '{0, 1, 8, 64, 256, 1024};
		int e;
		void'($urandom(32'h86f6));
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		// Reset values, reserved bits and a hole in the map
		rd(t16_pkg::ADDR_FLAGS, 8'h00, 8'h00);
		rd(t16_pkg::ADDR_FORCE, 8'h00, 8'h00);
		rd(8'h00, 8'h00, 8'h00);
		wr(t16_pkg::ADDR_MASK, 8'hFF);
		rd(t16_pkg::ADDR_MASK, 8'h27, 8'h27);
		wr(t16_pkg::ADDR_FLAGS, 8'hFF);
		rd(t16_pkg::ADDR_FLAGS, 8'h00, 8'h00);
		$display("test reset_map done");
		// One latch shared: a later high write replaces the earlier one
		r = 16'($urandom);
		wr16(t16_pkg::ADDR_CNT_L, r);
		rd16(t16_pkg::ADDR_CNT_L, r);
		wr(t16_pkg::ADDR_CMPA_H, r[7:0]);
		wr(t16_pkg::ADDR_CMPB_H, r[15:8]);
		wr(t16_pkg::ADDR_CMPA_L, 8'h5A);
		rd16(t16_pkg::ADDR_CMPA_L, {r[15:8], 8'h5A});
		$display("test shared_latch done");
		// Each tap counts twenty or so ticks; stopped counts none
		foreach (divs[i]) begin
			wr16(t16_pkg::ADDR_CNT_L, 16'h0000);
			wr(t16_pkg::ADDR_CTRL_B, 8'(i));
			cyc((i == 0) ? 50 : 20 * divs[i]);
			wr(t16_pkg::ADDR_CTRL_B, 8'h00);
			rd(t16_pkg::ADDR_CNT_L, (i == 0) ? 8'h00 : 8'h14, (i == 0) ? 8'h00 : 8'h18);
			rd(t16_pkg::ADDR_CNT_H, 8'h00, 8'h00);
		end
		// Five bench-driven pulses on the count pin, both edge modes
		for (e = 6; e < 8; e++) begin
			wr16(t16_pkg::ADDR_CNT_L, 16'h0000);
			wr(t16_pkg::ADDR_CTRL_B, 8'(e));
			repeat (5) begin
				cyc(4);
				ext_pin <= 1'b1;
				cyc(4);
				ext_pin <= 1'b0;
			end
			cyc(6);
			wr(t16_pkg::ADDR_CTRL_B, 8'h00);
			rd16(t16_pkg::ADDR_CNT_L, 16'h0005);
		end
		$display("test clock_select done");
		// Wrap, then match A, then match B
		wr16(t16_pkg::ADDR_CMPA_L, 16'h0004);
		wr16(t16_pkg::ADDR_CMPB_L, 16'h0008);
		wr16(t16_pkg::ADDR_CNT_L, 16'hFFF0);
		wr(t16_pkg::ADDR_MASK, 8'h07);
		gie <= 1'b1;
		wr(t16_pkg::ADDR_CTRL_B, 8'h01);
		wait_irq(2);
		wr(t16_pkg::ADDR_CTRL_B, 8'h00);
		rd(t16_pkg::ADDR_CNT_L, 8'h0C, 8'h0E);
		rd(t16_pkg::ADDR_FLAGS, 8'h07, 8'h07);
		check({4'h0, irq}, 8'h0E);
		// Global enable low hides every pending request
		gie <= 1'b0;
		cyc(3);
		check({4'h0, irq}, 8'h00);
		gie <= 1'b1;
		wr(t16_pkg::ADDR_MASK, 8'h00);
		wr(t16_pkg::ADDR_MASK, 8'h07);
		// Vector ack, write zero, write one
		@(posedge clk);
		ack <= 4'h2;
		@(posedge clk);
		ack <= 4'h0;
		rd(t16_pkg::ADDR_FLAGS, 8'h05, 8'h05);
		wr(t16_pkg::ADDR_FLAGS, 8'h00);
		rd(t16_pkg::ADDR_FLAGS, 8'h05, 8'h05);
		wr(t16_pkg::ADDR_FLAGS, 8'h04);
		rd(t16_pkg::ADDR_FLAGS, 8'h01, 8'h01);
		@(posedge clk);
		ack <= 4'hD;
		@(posedge clk);
		ack <= 4'h0;
		rd(t16_pkg::ADDR_FLAGS, 8'h00, 8'h00);
		$display("test match_flags done");
		// Writing the compare value itself loses the next match
		wr16(t16_pkg::ADDR_CMPB_L, 16'h0100);
		for (e = 3; e < 5; e++) begin
			wr(t16_pkg::ADDR_CTRL_B, 8'h01);
			wr16(t16_pkg::ADDR_CNT_L, 16'(e));
			cyc(2);
			wr(t16_pkg::ADDR_CTRL_B, 8'h00);
			rd(t16_pkg::ADDR_FLAGS, (e == 3) ? 8'h02 : 8'h00, (e == 3) ? 8'h02 : 8'h00);
			wr(t16_pkg::ADDR_FLAGS, 8'h27);
		end
		$display("test write_block done");
		// Wrong edge first, then the selected one
		wr(t16_pkg::ADDR_MASK, 8'h20);
		for (e = 0; e < 2; e++) begin
			r = 16'($urandom);
			wr(t16_pkg::ADDR_CTRL_B, (e == 1) ? 8'h40 : 8'h00);
			cap_pin <= e[0];
			cyc(8);
			wr(t16_pkg::ADDR_FLAGS, 8'h27);
			wr16(t16_pkg::ADDR_CNT_L, r);
			cap_pin <= ~e[0];
			cyc(8);
			rd(t16_pkg::ADDR_FLAGS, 8'h00, 8'h00);
			cap_pin <= e[0];
			wait_irq(0);
			rd16(t16_pkg::ADDR_CAP_L, r);
			rd(t16_pkg::ADDR_FLAGS, 8'h20, 8'h20);
		end
		// Capture register as top: pin ignored, flag at top instead
		wr16(t16_pkg::ADDR_CAP_L, 16'h0030);
		wr16(t16_pkg::ADDR_CNT_L, 16'h0000);
		wr(t16_pkg::ADDR_CTRL_B, 8'h18);
		wr(t16_pkg::ADDR_FLAGS, 8'h27);
		cap_pin <= 1'b0;
		cyc(8);
		rd(t16_pkg::ADDR_FLAGS, 8'h00, 8'h00);
		rd16(t16_pkg::ADDR_CAP_L, 16'h0030);
		wr(t16_pkg::ADDR_CTRL_B, 8'h19);
		wait_irq(0);
		wr(t16_pkg::ADDR_CTRL_B, 8'h18);
		rd(t16_pkg::ADDR_FLAGS, 8'h22, 8'h22);
		// Comparator source through the filter: a two-cycle glitch is dropped
		r = 16'($urandom);
		wr(t16_pkg::ADDR_CTRL_B, 8'hC0);
		cap_src <= 1'b1;
		wr16(t16_pkg::ADDR_CNT_L, r);
		wr(t16_pkg::ADDR_FLAGS, 8'h27);
		cmp_pin <= 1'b1;
		cyc(2);
		cmp_pin <= 1'b0;
		cyc(10);
		rd(t16_pkg::ADDR_FLAGS, 8'h00, 8'h00);
		cmp_pin <= 1'b1;
		wait_irq(0);
		rd16(t16_pkg::ADDR_CAP_L, r);
		$display("test capture done");
		// Forced matches in clear-on-match mode: outputs move, flags and count stay
		wr(t16_pkg::ADDR_CTRL_B, 8'h08);
		wr(t16_pkg::ADDR_CTRL_A, 8'h70);
		wr16(t16_pkg::ADDR_CNT_L, 16'h1234);
		wr(t16_pkg::ADDR_FLAGS, 8'h27);
		wr(t16_pkg::ADDR_FORCE, 8'hC0);
		cyc(2);
		check({6'h00, wave_a, wave_b}, 8'h03);
		wr(t16_pkg::ADDR_FORCE, 8'h80);
		cyc(2);
		check({6'h00, wave_a, wave_b}, 8'h01);
		rd(t16_pkg::ADDR_FLAGS, 8'h00, 8'h00);
		rd16(t16_pkg::ADDR_CNT_L, 16'h1234);
		rd(t16_pkg::ADDR_FORCE, 8'h00, 8'h00);
		cyc(2);
		$display("test force done");
		close_out();
	end
endmodule
`default_nettype wire
